/* logic/rtcs_consts.vh */
/*
 Constants for the RTC serial register port: slave address, state codes,
 timing figures and the cycle counts derived from them.
 Assumes a core clock given in kHz by RTCS_CLK_KHZ.
*/
`ifndef RTCS_CONSTS_VH
`define RTCS_CONSTS_VH

// Core clock rate in kHz, sized to the 24-bit timing counters
`define RTCS_CLK_KHZ 24'h00_2710

// Fixed 7-bit slave address
`define RTCS_DEV_ADDR 7'h51

// Bus transfer timeout in ms, and in core cycles
`define RTCS_TIMEOUT_MS 24'h00_03B6
`define RTCS_TIMEOUT_CYCLES (`RTCS_TIMEOUT_MS * `RTCS_CLK_KHZ)

// Supply return debounce, shortest and longest times in ms, and in core cycles
`define RTCS_DEB_SHORT_MS 24'h00_0001
`define RTCS_DEB_LONG_MS 24'h00_03E8
`define RTCS_DEB_SHORT_CYCLES (`RTCS_DEB_SHORT_MS * `RTCS_CLK_KHZ)
`define RTCS_DEB_LONG_CYCLES (`RTCS_DEB_LONG_MS * `RTCS_CLK_KHZ)

// Protocol state codes
`define RTCS_ST_IDLE 3'h0
`define RTCS_ST_ADDR 3'h1
`define RTCS_ST_RX 3'h2
`define RTCS_ST_ACK 3'h3
`define RTCS_ST_TX 3'h4
`define RTCS_ST_MACK 3'h5
`define RTCS_ST_SKIP 3'h6

`endif

/* logic/rtcs_sync2.v */
/*
 Two flip-flop synchroniser for a group of asynchronous inputs.
 Assumes the inputs are levels that stay for several core clocks.
*/
`timescale 1ns/10ps
`default_nettype none

module rtcs_sync2 #(
	parameter W = 1,
	parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
	input wire core_clk,
	input wire srst,
	input wire clkEn,
	input wire [W-1:0] asyncIn,
	output reg [W-1:0] syncOut
);

	// First stage, read only by the second
	reg [W-1:0] meta;

	// Both stages start at each line's idle level, so no false edge after reset
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			meta <= RST_VAL;
			syncOut <= RST_VAL;
		end
		else if (clkEn)
		begin
			meta <= asyncIn;
			syncOut <= meta;
		end
	end

endmodule
`default_nettype wire

/* logic/rtcs_i2c_slave.v */
/*
 Serial two-wire slave port giving an outside bus master byte access
 to the register space of a real-time clock.
 Assumes core_clk well above the bus clock, a register space that answers
 regRdData combinationally from regRdAddr in the same clock, and open-drain
 pads resolved outside from sdaOe.
*/
// What this block does
// [RULE_01] Slave only; clock input, data driven when responding
// [RULE_02] First byte after START is the address
// [RULE_03] Unlimited bytes, eight bits plus acknowledge each
// [RULE_04] Acknowledge every received byte when addressed
// [RULE_05] Master acknowledges read bytes except the last
// [RULE_06] Acknowledger holds data low through clock high
// [RULE_07] After master no-acknowledge, release data line
// [RULE_08] Answer only to address 51h, A2h/A3h
// [RULE_09] Address MSB first, then direction bit
// [RULE_10] Ignore foreign addresses without acknowledge
// [RULE_11] Write ends at STOP or next START
// [RULE_12] First write byte loads pointer; auto-increment
// [RULE_13] Write sequence: address, pointer, data bytes, STOP
// [RULE_14] Random read returns data from written pointer
// [RULE_15] Direct read continues from last address plus one
// [RULE_16] Master finishes each transfer within 950 ms
// [RULE_17] Timeout forces standby until next START
// [RULE_18] Pointer survives STOP and timeout
// [RULE_19] Repeated START acts as STOP then START
// [RULE_20] Backup supply: port released and reset
// [RULE_21] Master re-initialises with STOP, START afterwards
// [RULE_22] Block access for debounce after supply returns
// [RULE_23] Oversample lines; detect START/STOP; drive low only
`timescale 1ns/10ps
`default_nettype none
`include "rtcs_consts.vh"

module rtcs_i2c_slave #(
	parameter [23:0] TIMEOUT_CYCLES = `RTCS_TIMEOUT_CYCLES,
	parameter [23:0] DEB_SHORT_CYCLES = `RTCS_DEB_SHORT_CYCLES,
	parameter [23:0] DEB_LONG_CYCLES = `RTCS_DEB_LONG_CYCLES
) (
	input wire core_clk,
	input wire srst,
	input wire clkEn,
	input wire sclIn,
	input wire sdaIn,
	output reg sdaOut,
	output reg sdaOe,
	input wire backupSupplyState,
	input wire lowVoltageFlag,
	output reg [7:0] regRdAddr,
	input wire [7:0] regRdData,
	output reg regRdStrobe,
	output reg [7:0] regWrAddr,
	output reg [7:0] regWrData,
	output reg regWrStrobe,
	output reg busSelected,
	output reg busBlocked
);

	// Synchronised pins: scl, sda, backup state, low voltage flag
	wire [3:0] pinSync;
	// Sampled bus lines and their values one clock earlier
	wire sclS;
	wire sdaS;
	wire backupS;
	wire lowVoltS;
	reg sclD;
	reg sdaD;
	// Edge and condition strobes
	wire sclRise;
	wire sclFall;
	wire startCond;
	wire stopCond;
	// Protocol state
	reg [2:0] state;
	reg [3:0] bitCnt;
	reg [7:0] rxShift;
	reg [7:0] txShift;
	reg readDir;
	reg pointerNext;
	reg [23:0] busyCnt;
	reg [23:0] debCnt;
	reg backupD;

	// True when the received address byte selects this device
	function addrMatch;
		input [7:0] b;
		begin
			addrMatch = (b[7:1] == `RTCS_DEV_ADDR);
		end
	endfunction

	// Pins pass two flip-flops before use
	// Bus lines idle high, supply state and low voltage flag idle low
	rtcs_sync2 #(
		.W(4),
		.RST_VAL(4'h3)
	) uSync (
		.core_clk(core_clk),
		.srst(srst),
		.clkEn(clkEn),
		.asyncIn({lowVoltageFlag, backupSupplyState, sdaIn, sclIn}),
		.syncOut(pinSync)
	);

	assign sclS = pinSync[0];
	assign sdaS = pinSync[1];
	assign backupS = pinSync[2];
	assign lowVoltS = pinSync[3];

	// Clock line edges, seen through the oversampled copy
	assign sclRise = sclS & ~sclD; // RULE_23
	assign sclFall = ~sclS & sclD; // RULE_23
	// Data edges while clock stays high mark START and STOP
	assign startCond = sclS & sclD & sdaD & ~sdaS; // RULE_23
	assign stopCond = sclS & sclD & ~sdaD & sdaS; // RULE_23

	// Delayed line copies for edge detection
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			sclD <= 1'b1;
			sdaD <= 1'b1;
			backupD <= 1'b0;
		end
		else if (clkEn)
		begin
			sclD <= sclS;
			sdaD <= sdaS;
			backupD <= backupS;
		end
	end

	// Supply return debounce; bus access blocked while it runs
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			debCnt <= 24'h00_0000;
			busBlocked <= 1'b0;
		end
		else if (clkEn)
		begin
			if (backupS)
			begin
				// Backup supply: port disabled
				debCnt <= 24'h00_0000;
				busBlocked <= 1'b1; // RULE_20
			end
			else if (backupD)
			begin
				// Supply just returned: longer wait after low voltage
				debCnt <= lowVoltS ? DEB_LONG_CYCLES : DEB_SHORT_CYCLES; // RULE_22
				busBlocked <= 1'b1; // RULE_22
			end
			else if (debCnt > 24'h00_0001)
			begin
				// Still debouncing
				debCnt <= debCnt - 24'h00_0001; // RULE_22
			end
			else
			begin
				// Debounce over, access allowed again
				debCnt <= 24'h00_0000;
				busBlocked <= 1'b0; // RULE_22
			end
		end
	end

	// Main protocol engine
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			state <= `RTCS_ST_IDLE;
			bitCnt <= 4'h0;
			rxShift <= 8'h00;
			txShift <= 8'hFF;
			readDir <= 1'b0;
			pointerNext <= 1'b0;
			busyCnt <= 24'h00_0000;
			sdaOut <= 1'b0;
			sdaOe <= 1'b0;
			regRdAddr <= 8'h00;
			regRdStrobe <= 1'b0;
			regWrAddr <= 8'h00;
			regWrData <= 8'h00;
			regWrStrobe <= 1'b0;
			busSelected <= 1'b0;
		end
		else if (clkEn)
		begin
			// Pad drives only low; strobes last one clock
			sdaOut <= 1'b0; // RULE_23
			regRdStrobe <= 1'b0;
			regWrStrobe <= 1'b0;
			if (busBlocked || backupS)
			begin
				// Disabled: release line, reset state, keep pointer
				state <= `RTCS_ST_IDLE; // RULE_20
				sdaOe <= 1'b0; // RULE_20
				busSelected <= 1'b0;
				bitCnt <= 4'h0;
				busyCnt <= 24'h00_0000;
			end
			else if (startCond)
			begin
				// START or repeated START: fresh address phase
				state <= `RTCS_ST_ADDR; // RULE_02 RULE_19
				bitCnt <= 4'h0;
				sdaOe <= 1'b0;
				busSelected <= 1'b0;
				busyCnt <= 24'h00_0000;
			end
			else if (stopCond)
			begin
				// STOP ends any transfer, pointer untouched
				state <= `RTCS_ST_IDLE; // RULE_11 RULE_18
				sdaOe <= 1'b0;
				busSelected <= 1'b0;
				busyCnt <= 24'h00_0000;
			end
			else if (state != `RTCS_ST_IDLE && busyCnt >= TIMEOUT_CYCLES - 24'h00_0001)
			begin
				// Transfer too long: standby until next START
				state <= `RTCS_ST_IDLE; // RULE_17 RULE_18
				sdaOe <= 1'b0; // RULE_17
				busSelected <= 1'b0;
				busyCnt <= 24'h00_0000;
			end
			else
			begin
				// Transfer time runs from START
				if (state != `RTCS_ST_IDLE)
					busyCnt <= busyCnt + 24'h00_0001; // RULE_17
				case (state)
				`RTCS_ST_ADDR, `RTCS_ST_RX:
				begin
					// Receive eight bits, MSB first
					if (sclRise && bitCnt < 4'h8)
					begin
						rxShift <= {rxShift[6:0], sdaS}; // RULE_09
						bitCnt <= bitCnt + 4'h1; // RULE_03
					end
					else if (sclFall && bitCnt == 4'h8)
					begin
						bitCnt <= 4'h0;
						if (state == `RTCS_ST_ADDR)
						begin
							if (addrMatch(rxShift))
							begin
								// Selected: acknowledge, note direction
								readDir <= rxShift[0]; // RULE_08 RULE_09
								pointerNext <= ~rxShift[0]; // RULE_12
								busSelected <= 1'b1;
								sdaOe <= 1'b1; // RULE_04 RULE_06
								state <= `RTCS_ST_ACK;
							end
							else
							begin
								// Foreign address: stay silent
								state <= `RTCS_ST_SKIP; // RULE_10
							end
						end
						else
						begin
							if (pointerNext)
							begin
								// First byte of a write loads the pointer
								regRdAddr <= rxShift; // RULE_12 RULE_13
								pointerNext <= 1'b0;
							end
							else
							begin
								// Data byte written, pointer advances
								regWrAddr <= regRdAddr; // RULE_13
								regWrData <= rxShift;
								regWrStrobe <= 1'b1;
								regRdAddr <= regRdAddr + 8'h01; // RULE_12
							end
							sdaOe <= 1'b1; // RULE_04 RULE_06
							state <= `RTCS_ST_ACK;
						end
					end
				end
				`RTCS_ST_ACK:
				begin
					// After a received byte, hold low over the whole ninth clock; after a master acknowledge, only wait for its fall
					if (sclFall)
					begin
						if (readDir)
						begin
							// Load byte at pointer, drive its MSB
							txShift <= regRdData; // RULE_14 RULE_15
							regRdStrobe <= 1'b1;
							regRdAddr <= regRdAddr + 8'h01; // RULE_15
							sdaOe <= ~regRdData[7];
							state <= `RTCS_ST_TX;
						end
						else
						begin
							// Release, next byte from master
							sdaOe <= 1'b0; // RULE_06
							state <= `RTCS_ST_RX; // RULE_03
						end
						bitCnt <= 4'h0;
					end
				end
				`RTCS_ST_TX:
				begin
					// Shift out eight bits, change data while clock low
					if (sclRise)
						bitCnt <= bitCnt + 4'h1; // RULE_03
					else if (sclFall)
					begin
						if (bitCnt == 4'h8)
						begin
							// Release for the master acknowledge
							sdaOe <= 1'b0;
							state <= `RTCS_ST_MACK;
						end
						else
						begin
							txShift <= {txShift[6:0], 1'b1};
							sdaOe <= ~txShift[6]; // RULE_01
						end
					end
				end
				`RTCS_ST_MACK:
				begin
					// Sample the master acknowledge on the rising edge
					if (sclRise)
					begin
						if (sdaS)
						begin
							// No acknowledge: last byte, line stays released
							state <= `RTCS_ST_SKIP; // RULE_05 RULE_07
						end
						else
							state <= `RTCS_ST_ACK; // RULE_05
					end
				end
				`RTCS_ST_SKIP:
				begin
					// Silent until STOP or START
					sdaOe <= 1'b0; // RULE_07 RULE_10
				end
				default:
				begin
					// Idle: line released
					sdaOe <= 1'b0; // RULE_01
					busSelected <= 1'b0;
				end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

/* sim/rtcs_i2c_master.sv */
/* Bus master model for the RTC serial port.
 Assumes the bench resolves the open-drain data wire. */
`timescale 1ns/10ps
`default_nettype none
module rtcs_i2c_master (
	input wire logic core_clk,
	input wire logic sdaLine,
	output logic scl,
	output logic sdaLow
);
	// Idle: clock high, data released
	initial
	begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	// Quarter of the 800 ns bus period
	task q;
		repeat (2) @(negedge core_clk);
	endtask
	// Start or repeated start
	task start;
		q;
		sdaLow = 1'b0;
		q;
		scl = 1'b1;
		q;
		q;
		sdaLow = 1'b1;
		q;
		q;
		scl = 1'b0;
	endtask
	// Stop leaves the clock high
	task stop;
		q;
		sdaLow = 1'b1;
		q;
		scl = 1'b1;
		q;
		q;
		sdaLow = 1'b0;
		q;
	endtask
	// Data set mid-low, sampled at end of high
	task bit1(input logic b, output logic r);
		q;
		sdaLow = ~b;
		q;
		scl = 1'b1;
		q;
		q;
		r = sdaLine;
		scl = 1'b0;
	endtask
	// Eight bits then acknowledge bit
	task xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ak);
		for (int i = 7; i >= 0; i--)
			bit1(d[i], r[i]);
		bit1(a, ak);
	endtask
endmodule
`default_nettype wire

/* sim/rtcs_i2c_slave_properties.sv */
/* Checker for the RTC serial port.
 Assumes it is bound to the slave module, rtcs_i2c_slave. */
`timescale 1ns/10ps
`default_nettype none
module rtcs_i2c_slave_properties (
	input wire core_clk,
	input wire srst,
	input wire sclIn,
	input wire sdaIn,
	input wire sdaOut,
	input wire sdaOe,
	input wire backupSupplyState,
	input wire [7:0] regRdAddr,
	input wire regRdStrobe,
	input wire [7:0] regWrAddr,
	input wire regWrStrobe,
	input wire busSelected,
	input wire busBlocked
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// Stop seen on the wire
	sequence s_stop;
		sclIn && $past(sclIn) && $rose(sdaIn);
	endsequence
	property p_outLow; sdaOut == 1'b0; endproperty
	a_outLow: assert property (p_outLow) else $error("data driven high");
	property p_blockOn; backupSupplyState [*5] |-> busBlocked; endproperty
	a_blockOn: assert property (p_blockOn) else $error("not blocked");
	property p_blockOe; busBlocked |-> !sdaOe; endproperty
	a_blockOe: assert property (p_blockOe) else $error("drive while blocked");
	property p_deb; $fell(backupSupplyState) |-> busBlocked [*8]; endproperty
	a_deb: assert property (p_deb) else $error("debounce too short");
	property p_wrPulse; regWrStrobe |=> !regWrStrobe; endproperty
	a_wrPulse: assert property (p_wrPulse) else $error("write strobe long");
	property p_wrPtr; regWrStrobe |-> ##[0:1] (regRdAddr == regWrAddr + 8'h01); endproperty
	a_wrPtr: assert property (p_wrPtr) else $error("pointer not advanced");
	property p_rdInc; regRdStrobe |-> regRdAddr == $past(regRdAddr) + 8'h01; endproperty
	a_rdInc: assert property (p_rdInc) else $error("read pointer step");
	property p_oeHold; sclIn && $past(sclIn) && $past(sclIn, 2) |-> $stable(sdaOe); endproperty
	a_oeHold: assert property (p_oeHold) else $error("data moved in clock high");
	property p_stopDesel; s_stop |-> ##[1:8] !busSelected; endproperty
	a_stopDesel: assert property (p_stopDesel) else $error("still selected");
	property p_strobeSel; regWrStrobe || regRdStrobe |-> busSelected; endproperty
	a_strobeSel: assert property (p_strobeSel) else $error("access unselected");
endmodule
bind rtcs_i2c_slave rtcs_i2c_slave_properties chk (
	.core_clk(core_clk),
	.srst(srst),
	.sclIn(sclIn),
	.sdaIn(sdaIn),
	.sdaOut(sdaOut),
	.sdaOe(sdaOe),
	.backupSupplyState(backupSupplyState),
	.regRdAddr(regRdAddr),
	.regRdStrobe(regRdStrobe),
	.regWrAddr(regWrAddr),
	.regWrStrobe(regWrStrobe),
	.busSelected(busSelected),
	.busBlocked(busBlocked)
);
`default_nettype wire

/* sim/rtcs_i2c_slave_tb_top.sv */
/* Self-checking bench for the RTC serial port.
 Assumes the master model and a register-space stub here. */
`timescale 1ns/10ps
`default_nettype none
module rtcs_i2c_slave_tb_top;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic clkEn = 1'b1;
	logic backupSupplyState = 1'b0;
	logic lowVoltageFlag = 1'b0;
	logic sclIn, mLow, ak;
	logic [7:0] r;
	logic [7:0] mem [256];
	wire sdaOut, sdaOe, regRdStrobe, regWrStrobe, busSelected, busBlocked;
	wire [7:0] regRdAddr, regWrAddr, regWrData, regRdData;
	wire sdaIn;
	int n_fail = 0;
	int compares = 0;
	// Open-drain wire with pull-up
	assign sdaIn = ~(mLow | sdaOe);
	// Register space stub
	assign regRdData = mem[regRdAddr];
	always @(posedge core_clk)
		if (regWrStrobe)
			mem[regWrAddr] <= regWrData;
	always #50 core_clk = ~core_clk;
	rtcs_i2c_slave #(
		.TIMEOUT_CYCLES(24'h00_07D0),
		.DEB_SHORT_CYCLES(24'h00_0014),
		.DEB_LONG_CYCLES(24'h00_00C8)
	) uut (
		.core_clk(core_clk),
		.srst(srst),
		.clkEn(clkEn),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.sdaOut(sdaOut),
		.sdaOe(sdaOe),
		.backupSupplyState(backupSupplyState),
		.lowVoltageFlag(lowVoltageFlag),
		.regRdAddr(regRdAddr),
		.regRdData(regRdData),
		.regRdStrobe(regRdStrobe),
		.regWrAddr(regWrAddr),
		.regWrData(regWrData),
		.regWrStrobe(regWrStrobe),
		.busSelected(busSelected),
		.busBlocked(busBlocked)
	);
	rtcs_i2c_master m (.core_clk(core_clk), .sdaLine(sdaIn), .scl(sclIn), .sdaLow(mLow));
	task test_done;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	// Send a byte, expect acknowledge level e
	task wr(input logic [7:0] d, input logic e);
		m.xfer(d, 1'b1, r, ak);
		chk("ack", {7'h0, e}, {7'h0, ak});
	endtask
	task rd(input logic [7:0] e, input logic last);
		m.xfer(8'hFF, last, r, ak);
		chk("rdata", e, r);
	endtask
	task t_write;
		m.start;
		wr(8'hA2, 1'b0);
		wr(8'hFE, 1'b0);
		wr(8'h11, 1'b0);
		wr(8'h22, 1'b0);
		wr(8'h33, 1'b0);
		m.stop;
		chk("ptr", 8'h01, regRdAddr);
		chk("mem0", 8'h33, mem[0]);
	endtask
	task t_rread;
		m.start;
		wr(8'hA2, 1'b0);
		wr(8'hFE, 1'b0);
		m.start;
		wr(8'hA3, 1'b0);
		rd(8'h11, 1'b0);
		rd(8'h22, 1'b0);
		rd(8'h33, 1'b1);
		m.stop;
	endtask
	task t_cread;
		m.start;
		wr(8'hA3, 1'b0);
		rd(8'h01 ^ 8'h3C, 1'b1);
		m.stop;
	endtask
	task t_foreign;
		logic [7:0] fa [3];
		fa = '{8'hA0, 8'h22, 8'hA6};
		foreach (fa[i])
		begin
			m.start;
			wr(fa[i], 1'b1);
			wr(8'h00, 1'b1);
			m.stop;
		end
		chk("ptr", 8'h02, regRdAddr);
	endtask
	task t_timeout;
		m.start;
		wr(8'hA2, 1'b0);
		repeat (2100) @(negedge core_clk);
		wr(8'h05, 1'b1);
		m.stop;
		chk("ptr", 8'h02, regRdAddr);
		// Read cut by the timeout: byte at 02h is prefetched, then all ones
		m.start;
		wr(8'hA3, 1'b0);
		repeat (2100) @(negedge core_clk);
		rd(8'hFF, 1'b1);
		m.stop;
		chk("ptr", 8'h03, regRdAddr);
	endtask
	task t_backup;
		// Read from 03h: first bit is low, so the port is driving
		m.start;
		wr(8'hA3, 1'b0);
		repeat (4) @(negedge core_clk);
		chk("oe", 8'h01, {7'h0, sdaOe});
		backupSupplyState = 1'b1;
		repeat (10) @(negedge core_clk);
		chk("blk", 8'h01, {7'h0, busBlocked});
		chk("oe", 8'h00, {7'h0, sdaOe});
		lowVoltageFlag = 1'b1;
		backupSupplyState = 1'b0;
		m.stop;
		m.start;
		wr(8'hA2, 1'b1);
		m.stop;
		repeat (250) @(negedge core_clk);
		chk("blk", 8'h00, {7'h0, busBlocked});
		m.start;
		wr(8'hA2, 1'b0);
		m.stop;
		// Short debounce when the low voltage flag is clear
		lowVoltageFlag = 1'b0;
		backupSupplyState = 1'b1;
		repeat (10) @(negedge core_clk);
		backupSupplyState = 1'b0;
		repeat (10) @(negedge core_clk);
		chk("blk", 8'h01, {7'h0, busBlocked});
		repeat (30) @(negedge core_clk);
		chk("blk", 8'h00, {7'h0, busBlocked});
	endtask
	// Whole-run limit
	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		test_done;
	end
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = i[7:0] ^ 8'h3C;
		repeat (20) @(negedge core_clk);
		srst = 1'b0;
		repeat (4) @(negedge core_clk);
		t_write;
		t_rread;
		t_cread;
		t_foreign;
		t_timeout;
		t_backup;
		test_done;
	end
endmodule
`default_nettype wire
